// >>> design/ftic_convert.sv
// Float-to-integer convert unit with APB status/control registers
//
// How it works
// - Opcode 63, extended 815, bits 11-15 zero: truncating doubleword.
// - Doubleword convert yields a 64-bit signed integer, always toward zero.
// - Doubleword overflow saturates to max positive or to sign-bit-only.
// - Doubleword sets rounded-up, inexact, summary, sticky, invalid flags.
// - Result class flags after doubleword convert are left as they were.
// - In 32-bit mode the doubleword encoding raises illegal instruction.
// - Record bit 1 copies four summary bits into condition field 1.
// - Opcode 63, extended 14: word convert with current rounding mode.
// - Word convert rounds with the control register's rounding mode field.
// - Word result goes to low word; upper word driven to zero.
// - Word converts saturate to 0x7fffffff or 0x80000000.
// - Word converts update rounded-up, inexact, summary, sticky, invalid.
// - Opcode 63, extended 15: word convert toward zero.
// - Truncating word convert ignores the rounding mode field.
// - Alternate spellings share encodings, so behave identically.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none

module ftic_convert
   import ftic_pkg::*;
(
   // Clock and reset
   input  wire  logic        ref_clk,
   input  wire  logic        reset_n,
   // APB slave
   input  wire  logic [7:0]  paddr,
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [31:0] pwdata,
   output var   logic [31:0] prdata,
   output var   logic        pready,
   output var   logic        pslverr,
   // Instruction issue
   input  wire  logic        issueValid,
   input  wire  logic [31:0] instrWord,
   input  wire  logic [63:0] sourceFloatReg,
   // Result to register file
   output var   logic        resultValid,
   output var   logic        resultWrite,
   output var   logic [4:0]  targetFloatReg,
   output var   logic [63:0] resultValue,
   output var   logic        illegalInstr,
   output var   logic        cr1Valid,
   output var   logic [3:0]  condField1,
   // Interrupt
   output var   logic        irq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      ftic_apb_t              apbState;
      logic                   pready;
      logic                   pslverr;
      logic [31:0]            prdata;
      ftic_ctrl_t             ctrl;
      ftic_fstat_t            fstat;
      logic [3:0]             cr1;
      logic [IRQ_BITS-1:0]    irqStatus;
      logic [IRQ_BITS-1:0]    irqMask;
      logic                   irq;
      ftic_result_t           res;
   } ftic_state_t;

   ftic_state_t state;
   ftic_state_t next_state;
   logic        rstMeta;
   logic        rstSync;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end
      else
      begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // ------------------------------------------------------------
   // Conversion datapath
   // ------------------------------------------------------------
   function automatic ftic_cvt_t convert(
      input logic [63:0] op,
      input logic [1:0]  mode,
      input logic        isWord
   );
      ftic_cvt_t    r;
      logic         sgn;
      logic [10:0]  ex;
      logic [52:0]  mant;
      logic         isNan;
      logic         isInf;
      logic         huge;
      logic [10:0]  shr;
      logic [127:0] fixed;
      logic [63:0]  intPart;
      logic         guard;
      logic         sticky;
      logic         up;
      logic [64:0]  mag;
      logic [64:0]  limit;
      logic         over;
      logic [63:0]  signedVal;
      r       = '0;
      sgn     = op[63];
      ex      = op[62:52];
      mant    = {|ex, op[51:0]};
      isNan   = (&ex) & (|op[51:0]);
      isInf   = (&ex) & ~(|op[51:0]);
      huge    = (ex >= EXP_HUGE);
      fixed   = '0;
      intPart = '0;
      guard   = 1'b0;
      sticky  = 1'b0;
      // Denormals share the scale of the smallest normal exponent
      if (ex >= EXP_UNIT)
      begin
         shr     = ex - EXP_UNIT;
         intPart = huge ? '0 : ({11'h000, mant} << shr[3:0]);
      end
      else
      begin
         shr = EXP_UNIT - ((ex == 11'h000) ? 11'h001 : ex);
         // Beyond 64 only sticky matters, so cap to keep the shifter small
         if (shr > SHR_CAP)
            shr = SHR_CAP;
         fixed   = {11'h000, mant, 64'h0} >> shr[6:0];
         intPart = fixed[127:64];
         guard   = fixed[63];
         sticky  = |fixed[62:0];
      end
      case (mode)
         RM_NEAREST: up = guard & (sticky | intPart[0]);
         RM_ZERO:    up = 1'b0;
         RM_POS:     up = (guard | sticky) & ~sgn;
         RM_NEG:     up = (guard | sticky) & sgn;
         default:    up = 1'b0;
      endcase
      mag   = {1'b0, intPart} + {64'h0, up};
      limit = isWord ? MAX_WORD : MAX_DWORD;
      over  = huge | isInf | (sgn ? (mag > limit + 65'h1) : (mag > limit));
      signedVal = sgn ? (64'h0 - mag[63:0]) : mag[63:0];
      if (isNan | over)
      begin
         // NaN takes the negative limit; range errors follow the sign
         r.invalid = 1'b1;
         r.snan    = isNan & ~op[51];
         if (isWord)
            r.value = {32'h0, (sgn | isNan) ? SAT_NEG_W : SAT_POS_W};
         else
            r.value = (sgn | isNan) ? SAT_NEG_D : SAT_POS_D;
      end
      else
      begin
         r.roundedUp = up;
         r.inexact   = guard | sticky;
         r.value     = isWord ? {32'h0, signedVal[31:0]} : signedVal;
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic        isConvOp;
   logic        isDword;
   logic        isWordRound;
   logic        isWordTrunc;
   logic        recordBit;
   logic        dwordIllegal;
   logic        doConvert;
   logic [1:0]  effMode;
   ftic_cvt_t   cvt;

   assign isConvOp    = issueValid & (instrWord[31:26] == OPC_PRIMARY);
   assign isDword     = isConvOp & (instrWord[10:1] == XO_DWORD_TRUNC);
   // Alternate spellings assemble to these same encodings
   assign isWordRound = isConvOp &
                        (instrWord[10:1] == XO_WORD_ROUND);
   assign isWordTrunc = isConvOp &
                        (instrWord[10:1] == XO_WORD_TRUNC);
   assign recordBit   = instrWord[0];
   assign dwordIllegal = isDword & (~state.ctrl.wide64 |
                         (instrWord[20:16] != FIELD_ZERO));
   assign doConvert   = (isDword & ~dwordIllegal) | isWordRound | isWordTrunc;
   assign effMode     = isWordRound ? state.ctrl.roundingModeField
                                    : RM_ZERO;
   assign cvt         = convert(sourceFloatReg, effMode, ~isDword);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic        apbDone;
      logic        mapped;
      logic [31:0] rdata;
      ftic_fstat_t f;
      logic        newExc;
      logic [IRQ_BITS-1:0] events;
      apbDone = 1'b0;
      mapped  = 1'b0;
      rdata   = '0;
      f       = '0;
      newExc  = 1'b0;
      events  = '0;
      next_state = state;
      next_state.res.valid    = 1'b0;
      next_state.res.write    = 1'b0;
      next_state.res.illegal  = 1'b0;
      next_state.res.cr1Valid = 1'b0;

      // Register decode
      case (paddr)
         ADDR_CTRL:
         begin
            mapped = 1'b1;
            rdata  = {27'h0, state.ctrl};
         end
         ADDR_FSTAT:
         begin
            mapped = 1'b1;
            rdata  = {18'h0, state.fstat};
         end
         ADDR_CR1:
         begin
            mapped = 1'b1;
            rdata  = {28'h0, state.cr1};
         end
         ADDR_ISTAT:
         begin
            mapped = 1'b1;
            rdata  = {29'h0, state.irqStatus};
         end
         ADDR_IMASK:
         begin
            mapped = 1'b1;
            rdata  = {29'h0, state.irqMask};
         end
         default:
         begin
            mapped = 1'b0;
            rdata  = '0;
         end
      endcase

      // APB: one wait state, answer registered
      case (state.apbState)
         APB_IDLE:
         begin
            next_state.pready = 1'b0;
            if (psel & penable)
            begin
               next_state.pready   = 1'b1;
               next_state.pslverr  = ~mapped;
               next_state.prdata   = (pwrite | ~mapped) ? 32'h0 : rdata;
               next_state.apbState = APB_ACK;
            end
         end
         APB_ACK:
         begin
            apbDone             = psel & penable;
            next_state.pready   = 1'b0;
            next_state.pslverr  = 1'b0;
            next_state.apbState = APB_IDLE;
         end
         default:
         begin
            next_state.pready   = 1'b0;
            next_state.apbState = APB_IDLE;
         end
      endcase

      // Writes take effect at the completing edge
      if (apbDone & pwrite)
      begin
         case (paddr)
            ADDR_CTRL:  next_state.ctrl    = pwdata[4:0];
            ADDR_FSTAT: next_state.fstat   = pwdata[13:0];
            ADDR_IMASK: next_state.irqMask = pwdata[IRQ_BITS-1:0];
            default:    next_state.ctrl    = next_state.ctrl;
         endcase
      end

      // Convert: flags update on top of any same-cycle software write
      f = next_state.fstat;
      if (doConvert)
      begin
         newExc = (cvt.invalid & ~f.invalidConvertFlag) |
                  (cvt.snan & ~f.signallingNanFlag) |
                  (cvt.inexact & ~f.stickyInexact);
         f.roundedUpFlag      = cvt.roundedUp;
         f.inexactFlag        = cvt.inexact;
         f.stickyInexact      = f.stickyInexact | cvt.inexact;
         f.invalidConvertFlag = f.invalidConvertFlag | cvt.invalid;
         f.signallingNanFlag  = f.signallingNanFlag | cvt.snan;
         f.exceptionSummary   = f.exceptionSummary | newExc;
         f.invalidOpSummary   = f.invalidConvertFlag | f.signallingNanFlag;
         f.enabledExceptionSummary =
            (f.invalidOpSummary & state.ctrl.invalidEnable) |
            (f.stickyInexact & state.ctrl.inexactEnable);
         // Class flags kept as they were: legal for the undefined case
         // and correct when an enabled invalid exception suppresses it
         f.resultClassFlags   = next_state.fstat.resultClassFlags;
         next_state.fstat     = f;
         next_state.res.valid  = 1'b1;
         // Enabled invalid exception leaves the target untouched
         next_state.res.write  = ~(cvt.invalid & state.ctrl.invalidEnable);
         next_state.res.target = instrWord[25:21];
         next_state.res.value  = cvt.value;
         if (recordBit)
         begin
            next_state.cr1 = {f.exceptionSummary,
                              f.enabledExceptionSummary,
                              f.invalidOpSummary,
                              f.overflowBit};
            next_state.res.cr1Valid = 1'b1;
         end
      end
      next_state.res.illegal = dwordIllegal;

      // Interrupt status: read clears, a new event wins over the clear
      events[IRQ_DONE]    = doConvert;
      events[IRQ_ILLEGAL] = dwordIllegal;
      events[IRQ_INVALID] = doConvert & cvt.invalid;
      for (int i = 0; i < IRQ_BITS; i++)
      begin
         if (apbDone & ~pwrite & (paddr == ADDR_ISTAT))
            next_state.irqStatus[i] = 1'b0;
         if (events[i])
            next_state.irqStatus[i] = 1'b1;
      end
      next_state.irq = |(next_state.irqStatus & next_state.irqMask);
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstSync)
   begin
      if (!rstSync)
      begin
         state          <= '0;
         state.apbState <= APB_IDLE;
         state.ctrl     <= CTRL_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign prdata         = state.prdata;
   assign pready         = state.pready;
   assign pslverr        = state.pslverr;
   assign resultValid    = state.res.valid;
   assign resultWrite    = state.res.write;
   assign targetFloatReg = state.res.target;
   assign resultValue    = state.res.value;
   assign illegalInstr   = state.res.illegal;
   assign cr1Valid       = state.res.cr1Valid;
   assign condField1     = state.cr1;
   assign irq            = state.irq;

endmodule

`default_nettype wire

// >>> design/ftic_pkg.sv
// Shared constants and carrier types for the float-to-integer convert unit
package ftic_pkg;

   // ------------------------------------------------------------
   // Instruction encoding
   // ------------------------------------------------------------
   localparam logic [5:0]  OPC_PRIMARY   = 6'h3f;   // 63
   localparam logic [9:0]  XO_DWORD_TRUNC = 10'h32f; // 815
   localparam logic [9:0]  XO_WORD_ROUND = 10'h00e;  // 14
   localparam logic [9:0]  XO_WORD_TRUNC = 10'h00f;  // 15
   localparam logic [4:0]  FIELD_ZERO    = 5'h00;

   // ------------------------------------------------------------
   // Rounding mode encodings
   // ------------------------------------------------------------
   localparam logic [1:0]  RM_NEAREST = 2'h0;
   localparam logic [1:0]  RM_ZERO    = 2'h1;
   localparam logic [1:0]  RM_POS     = 2'h2;
   localparam logic [1:0]  RM_NEG     = 2'h3;

   // ------------------------------------------------------------
   // Floating-point format and integer limits
   // ------------------------------------------------------------
   localparam logic [10:0] EXP_UNIT   = 11'h433;  // 1075, unit of lsb
   localparam logic [10:0] EXP_HUGE   = 11'h43f;  // 1087, value >= 2^64
   localparam logic [10:0] SHR_CAP    = 11'h040;  // 64
   localparam logic [64:0] MAX_DWORD  = 65'h0_7fff_ffff_ffff_ffff;
   localparam logic [64:0] MAX_WORD   = 65'h0_0000_0000_7fff_ffff;
   localparam logic [63:0] SAT_POS_D  = 64'h7fff_ffff_ffff_ffff;
   localparam logic [63:0] SAT_NEG_D  = 64'h8000_0000_0000_0000;
   localparam logic [31:0] SAT_POS_W  = 32'h7fff_ffff;
   localparam logic [31:0] SAT_NEG_W  = 32'h8000_0000;

   // ------------------------------------------------------------
   // Register map (byte addresses) and reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_FSTAT  = 8'h04;
   localparam logic [7:0]  ADDR_CR1    = 8'h08;
   localparam logic [7:0]  ADDR_ISTAT  = 8'h0c;
   localparam logic [7:0]  ADDR_IMASK  = 8'h10;
   localparam logic [4:0]  CTRL_RESET  = 5'h10;   // 64-bit mode, nearest
   localparam int          IRQ_BITS    = 3;
   localparam int          IRQ_DONE    = 0;
   localparam int          IRQ_ILLEGAL = 1;
   localparam int          IRQ_INVALID = 2;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_ACK  = 2'b10
   } ftic_apb_t;

   typedef struct packed {
      logic       wide64;        // 1 = 64-bit implementation
      logic       inexactEnable;
      logic       invalidEnable;
      logic [1:0] roundingModeField;
   } ftic_ctrl_t;

   typedef struct packed {
      logic [4:0] resultClassFlags;
      logic       exceptionSummary;
      logic       enabledExceptionSummary;
      logic       invalidOpSummary;
      logic       overflowBit;
      logic       stickyInexact;
      logic       signallingNanFlag;
      logic       invalidConvertFlag;
      logic       roundedUpFlag;
      logic       inexactFlag;
   } ftic_fstat_t;

   typedef struct packed {
      logic [63:0] value;
      logic        roundedUp;
      logic        inexact;
      logic        invalid;
      logic        snan;
   } ftic_cvt_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [4:0]  target;
      logic [63:0] value;
      logic        illegal;
      logic        cr1Valid;
   } ftic_result_t;

endpackage

// >>> verif/ftic_convert_assertions.sv
// Port-level checks for the float-to-integer convert unit
`timescale 1ns/1ns
`default_nettype none

module ftic_convert_assertions
   import ftic_pkg::*;
(
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        reset_n,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   // Issue and result
   input wire logic        issueValid,
   input wire logic [31:0] instrWord,
   input wire logic [63:0] sourceFloatReg,
   input wire logic        resultValid,
   input wire logic [63:0] resultValue,
   input wire logic [4:0]  targetFloatReg,
   input wire logic        illegalInstr,
   input wire logic        cr1Valid,
   input wire logic [3:0]  condField1
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   logic [10:0] expo;
   logic        isNan;
   logic        isWord;
   logic        isDw;

   assign expo   = sourceFloatReg[62:52];
   assign isNan  = (expo == 11'h7ff) && (sourceFloatReg[51:0] != 52'h0);
   assign isWord = issueValid && (instrWord[31:26] == OPC_PRIMARY)
                   && ((instrWord[10:1] == XO_WORD_ROUND)
                   || (instrWord[10:1] == XO_WORD_TRUNC));
   assign isDw   = issueValid && (instrWord[31:26] == OPC_PRIMARY)
                   && (instrWord[10:1] == XO_DWORD_TRUNC);

   sequence s_word_issue;
      isWord;
   endsequence

   sequence s_apb_start;
      psel && $rose(penable);
   endsequence

   a_word_taken:
   assert property (s_word_issue |=> resultValid && !illegalInstr
                    && targetFloatReg == $past(instrWord[25:21]))
      else $error("word convert gave no result");
   a_word_high:
   assert property (s_word_issue ##0 (!sourceFloatReg[63]
                    && expo >= 11'h41e && !isNan)
                    |=> resultValue[31:0] == SAT_POS_W)
      else $error("word convert did not clamp high");
   a_word_low:
   assert property (s_word_issue ##0 (isNan || (sourceFloatReg[63]
                    && expo >= 11'h41e))
                    |=> resultValue[31:0] == SAT_NEG_W)
      else $error("word convert did not clamp low");
   a_trunc_fraction:
   assert property (isWord && instrWord[10:1] == XO_WORD_TRUNC
                    && expo < 11'h3ff |=> resultValue[31:0] == 32'h0)
      else $error("fraction not cut to zero");
   a_dword_high:
   assert property (isDw && instrWord[20:16] == FIELD_ZERO
                    && !sourceFloatReg[63] && expo >= 11'h43e && !isNan
                    |=> illegalInstr || resultValue == SAT_POS_D)
      else $error("doubleword did not clamp high");
   a_dword_field:
   assert property (isDw && instrWord[20:16] != FIELD_ZERO
                    |=> illegalInstr && !resultValid)
      else $error("bad doubleword field accepted");
   a_record_set:
   assert property (s_word_issue ##0 instrWord[0] |=> cr1Valid)
      else $error("record bit ignored");
   a_record_clear:
   assert property ((isWord || isDw) && !instrWord[0]
                    |=> !cr1Valid && $stable(condField1))
      else $error("condition field changed without record");
   a_idle_quiet:
   assert property (!issueValid
                    |=> !resultValid && !illegalInstr && !cr1Valid)
      else $error("result without issue");
   a_apb_wait:
   assert property (s_apb_start |=> pready ##1 !pready)
      else $error("APB answer not after one wait state");
endmodule

bind ftic_convert ftic_convert_assertions u_chk (.ref_clk, .reset_n,
   .psel, .penable, .pready, .issueValid, .instrWord, .sourceFloatReg,
   .resultValid, .resultValue, .targetFloatReg, .illegalInstr, .cr1Valid,
   .condField1);

`default_nettype wire

// >>> verif/ftic_issue_model.sv
// Issue-side stand-in that feeds converts to the unit
`timescale 1ns/1ns
`default_nettype none

module ftic_issue_model
(
   // Clock
   input  wire logic        ref_clk,
   // Issue port
   output var  logic        issueValid,
   output var  logic [31:0] instrWord,
   output var  logic [63:0] sourceFloatReg
);
   logic sending;

   initial
   begin
      sending        = 1'b0;
      issueValid     = 1'b0;
      instrWord      = 32'h0;
      sourceFloatReg = 64'h0;
   end

   // Word and operand mean nothing between issues, so keep them moving
   always @(posedge ref_clk)
   begin
      if (!sending && !issueValid)
      begin
         instrWord      <= ~instrWord;
         sourceFloatReg <= ~sourceFloatReg;
      end
   end

   task send(input logic [31:0] w, input logic [63:0] op);
      sending = 1'b1;
      @(posedge ref_clk);
      issueValid     <= 1'b1;
      instrWord      <= w;
      sourceFloatReg <= op;
      @(posedge ref_clk);
      issueValid <= 1'b0;
      sending = 1'b0;
   endtask
endmodule

`default_nettype wire

// >>> verif/ftic_convert_tb.sv
// Self-checking bench for the float-to-integer convert unit
`timescale 1ns/1ns
`default_nettype none

module ftic_convert_tb
   import ftic_pkg::*;
();
   typedef struct packed {
      logic [9:0]  xo;
      logic [1:0]  rm;
      logic [63:0] op;
      logic [63:0] res;
      logic [15:0] fst;
   } ftic_case_t;

   localparam logic [63:0] D_2P5 = 64'h4004_0000_0000_0000;
   localparam logic [63:0] D_BIG = 64'h4202_a05f_2000_0000;
   localparam logic [63:0] NEG   = 64'h8000_0000_0000_0000;

   logic        ref_clk;
   logic        reset_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        issueValid;
   logic [31:0] instrWord;
   logic [63:0] sourceFloatReg;
   logic        resultValid;
   logic        resultWrite;
   logic [4:0]  targetFloatReg;
   logic [63:0] resultValue;
   logic        illegalInstr;
   logic        cr1Valid;
   logic [3:0]  condField1;
   logic        irq;
   logic [31:0] rd;
   logic        er;
   int          error_cnt;
   int          num_checks;
   int          cycles;

   ftic_case_t cases [15] = '{
      '{XO_WORD_TRUNC, RM_NEAREST, D_2P5, 64'h2, 16'h111},
      '{XO_WORD_ROUND, RM_NEAREST, D_2P5, 64'h2, 16'h111},
      '{XO_WORD_ROUND, RM_NEAREST, 64'h400c_0000_0000_0000, 64'h4, 16'h113},
      '{XO_WORD_ROUND, RM_ZERO, D_2P5 | NEG, 64'hffff_fffe, 16'h111},
      '{XO_WORD_ROUND, RM_POS, D_2P5, 64'h3, 16'h113},
      '{XO_WORD_ROUND, RM_NEG, D_2P5 | NEG, 64'hffff_fffd, 16'h113},
      '{XO_WORD_TRUNC, RM_POS, D_2P5, 64'h2, 16'h111},
      '{XO_WORD_TRUNC, RM_NEAREST, D_BIG, 64'h7fff_ffff, 16'h144},
      '{XO_WORD_ROUND, RM_NEG, D_BIG | NEG, 64'h8000_0000, 16'h144},
      '{XO_DWORD_TRUNC, RM_POS, 64'h4202_a05f_2004_0000, 64'h2_540b_e400,
        16'h111},
      '{XO_DWORD_TRUNC, RM_NEAREST, 64'h43e0_0000_0000_0000, SAT_POS_D,
        16'h144},
      '{XO_DWORD_TRUNC, RM_NEAREST, 64'hc3f0_0000_0000_0000, NEG, 16'h144},
      '{XO_DWORD_TRUNC, RM_NEAREST, 64'h7ff8_0000_0000_0000, NEG, 16'h144},
      '{XO_WORD_TRUNC, RM_NEAREST, 64'h7ff0_0000_0000_0001, 64'h8000_0000,
        16'h14c},
      '{XO_WORD_TRUNC, RM_NEG, 64'hbfe8_0000_0000_0000, 64'h0, 16'h111}
   };

   ftic_convert dut (.ref_clk, .reset_n, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .issueValid, .instrWord,
      .sourceFloatReg, .resultValid, .resultWrite, .targetFloatReg,
      .resultValue, .illegalInstr, .cr1Valid, .condField1, .irq);

   ftic_issue_model model (.ref_clk, .issueValid, .instrWord,
      .sourceFloatReg);

   initial ref_clk = 1'b0;
   always #10 ref_clk = ~ref_clk;

   // Ceiling well above the few hundred cycles the tests need
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         error_cnt++;
         finish_test();
      end
   end

   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input logic [63:0] got, input logic [63:0] exp, input string s);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Only the bench ceiling ends a wait for a slave that never answers
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] mk(logic [9:0] xo, logic [4:0] t,
                                      logic r, logic [4:0] f);
      return {OPC_PRIMARY, t, f, 5'h02, xo, r};
   endfunction

   task issue(input logic [31:0] w, input logic [63:0] op);
      model.send(w, op);
      #1;
   endtask

   initial
   begin
      {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {error_cnt, num_checks, cycles} = '0;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      apb(0, ADDR_CTRL, 32'h0);
      chk(64'(rd), 64'h10, "ctrl reset");
      apb(1, ADDR_CR1, 32'hf);
      apb(0, ADDR_CR1, 32'h0);
      chk(64'(rd), 64'h0, "cr1 read-only");
      apb(0, 8'h14, 32'h0);
      chk(64'({er, rd}), 64'h1_0000_0000, "unmapped");
      $display("register test done");
      for (int i = 0; i < 15; i++)
      begin
         apb(1, ADDR_CTRL, 32'h10 | 32'(cases[i].rm));
         apb(1, ADDR_FSTAT, 32'h0);
         issue(mk(cases[i].xo, i[4:0], i[0], 5'h0), cases[i].op);
         chk(64'({resultValid, resultWrite}), 64'h3, "valid");
         chk(resultValue, cases[i].res, "value");
         chk(64'(targetFloatReg), 64'(i[4:0]), "target");
         if (i[0])
            chk(64'(condField1), 64'({cases[i].fst[8], 1'b0,
                cases[i].fst[6], 1'b0}), "cr1");
         apb(0, ADDR_FSTAT, 32'h0);
         chk(64'(rd), 64'(cases[i].fst), "flags");
      end
      $display("convert test done");
      apb(0, ADDR_ISTAT, 32'h0);
      apb(1, ADDR_IMASK, 32'h2);
      issue(mk(XO_WORD_TRUNC, 5'h1, 1'b0, 5'h0), D_2P5);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(64'(irq), 64'h0, "masked irq");
      issue(mk(XO_DWORD_TRUNC, 5'h1, 1'b0, 5'h3), D_2P5);
      chk(64'({illegalInstr, resultValid}), 64'h2, "bad field");
      repeat (2) @(posedge ref_clk);
      #1;
      chk(64'(irq), 64'h1, "irq");
      apb(0, ADDR_ISTAT, 32'h0);
      chk(64'(rd), 64'h3, "istat");
      repeat (2) @(posedge ref_clk);
      #1;
      chk(64'(irq), 64'h0, "irq cleared");
      apb(1, ADDR_CTRL, 32'h1c);
      apb(1, ADDR_FSTAT, 32'h0);
      issue(mk(XO_WORD_TRUNC, 5'h2, 1'b1, 5'h0), 64'h7ff8_0000_0000_0000);
      chk(64'({resultWrite, condField1}), 64'h0e, "enabled invalid");
      apb(0, ADDR_FSTAT, 32'h0);
      chk(64'(rd), 64'h1c4, "enabled flags");
      apb(1, ADDR_CTRL, 32'h0);
      issue(mk(XO_DWORD_TRUNC, 5'h1, 1'b0, 5'h0), D_2P5);
      chk(64'({illegalInstr, resultValid}), 64'h2, "32-bit mode");
      $display("fault test done");
      finish_test();
   end
endmodule

`default_nettype wire
